// ==== hw/timer16_cc.sv ====
// compare, capture and event flag logic of a 16-bit timer with avalon-mm slave
`timescale 1ns/1ps
module timer16_cc
   import timer16_cc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic [5:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   input wire logic [15:0] i_count_value,
   input wire logic i_count_tick,
   input wire logic i_count_written,
   input wire logic i_count_overflow,
   input wire logic i_capture_pin,
   input wire logic i_comparator_out,
   input wire logic i_capture_vector_taken,
   input wire logic i_compare_a_vector_taken,
   input wire logic i_compare_b_vector_taken,
   input wire logic i_overflow_vector_taken,
   output logic o_compare_a_match,
   output logic o_compare_b_match,
   output logic o_capture_is_top,
   output logic [15:0] o_capture_value,
   output logic [15:0] o_compare_value_a,
   output logic [15:0] o_compare_value_b,
   output logic o_capture_irq,
   output logic o_compare_a_irq,
   output logic o_compare_b_irq,
   output logic o_overflow_irq
);

   // modes that take TOP from the capture value
   function automatic logic capture_as_top(input logic [3:0] mode);
      capture_as_top = (mode == MODE_PFC_CAP) || (mode == MODE_PC_CAP) ||
                       (mode == MODE_CTC_CAP) || (mode == MODE_FAST_CAP);
   endfunction

   logic ack_r;
   logic [7:0] irq_enable_r;
   logic [7:0] event_flags_r;
   logic [7:0] high_latch_r;
   logic [15:0] compare_value_a_r;
   logic [15:0] compare_value_b_r;
   logic [15:0] capture_value_r;
   logic [3:0] waveform_mode_select_r;
   logic capture_edge_select_r;
   logic capture_noise_filter_enable_r;
   logic capture_source_comparator_r;
   logic [FILTER_DEPTH-1:0] sample_r;
   logic filtered_r;
   logic capture_level_r;
   logic capture_event_r;
   logic match_block_r;
   logic match_a_r;
   logic match_b_r;
   logic top_reach_r;
   logic wr_go;
   logic rd_go;
   logic capture_raw;
   logic capture_in;
   logic capture_edge;
   logic mode_cap_top;
   logic [7:0] flag_set;
   logic [7:0] flag_clr;
   logic [7:0] flag_nxt;
   logic force_a;
   logic force_b;

   // one wait cycle per access keeps read data and write effects aligned
   assign wr_go = i_write && ack_r && i_byteenable[0];
   assign rd_go = i_read && !ack_r;
   assign mode_cap_top = capture_as_top(waveform_mode_select_r);
   assign force_a = wr_go && (i_address == ADDR_CONTROL) && i_writedata[CTL_FORCE_A];
   assign force_b = wr_go && (i_address == ADDR_CONTROL) && i_writedata[CTL_FORCE_B];

   // bus handshake: waitrequest is its own flop holding the inverse of ack, low one cycle per request
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         ack_r <= 1'b0;
         o_waitrequest <= 1'b1;
      end
      else
      begin
         ack_r <= (i_read || i_write) && !ack_r;
         o_waitrequest <= !((i_read || i_write) && !ack_r);
      end
   end

   // read data loaded in the first cycle, stands at the acknowledging edge
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         o_readdata <= 32'h0000_0000;
      else if (rd_go)
      begin
         o_readdata <= 32'h0000_0000;
         case (i_address)
            ADDR_IRQ_ENABLE: o_readdata[7:0] <= irq_enable_r & EVENT_MASK;
            ADDR_EVENT_FLAGS: o_readdata[7:0] <= event_flags_r & EVENT_MASK;
            ADDR_CMP_A_LO: o_readdata[7:0] <= compare_value_a_r[7:0];
            ADDR_CMP_A_HI: o_readdata[7:0] <= compare_value_a_r[15:8];
            ADDR_CMP_B_LO: o_readdata[7:0] <= compare_value_b_r[7:0];
            ADDR_CMP_B_HI: o_readdata[7:0] <= compare_value_b_r[15:8];
            ADDR_CAP_LO: o_readdata[7:0] <= capture_value_r[7:0];
            ADDR_CAP_HI: o_readdata[7:0] <= high_latch_r;
            ADDR_CONTROL: o_readdata[7:0] <= {1'b0, capture_source_comparator_r,
               capture_noise_filter_enable_r, capture_edge_select_r, waveform_mode_select_r};
            default: o_readdata <= 32'h0000_0000; // unmapped reads as zero
         endcase
      end
   end

   // shared high-byte latch: written by high-byte writes, loaded by capture low reads
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         high_latch_r <= RESET_BYTE;
      else if (rd_go && (i_address == ADDR_CAP_LO))
         high_latch_r <= capture_value_r[15:8];
      else if (wr_go && ((i_address == ADDR_CMP_A_HI) || (i_address == ADDR_CMP_B_HI) ||
               (i_address == ADDR_CAP_HI)))
         high_latch_r <= i_writedata[7:0];
   end

   // compare values commit both bytes on the low-byte write
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         compare_value_a_r <= RESET_WORD;
         compare_value_b_r <= RESET_WORD;
      end
      else if (wr_go && (i_address == ADDR_CMP_A_LO))
         compare_value_a_r <= {high_latch_r, i_writedata[7:0]};
      else if (wr_go && (i_address == ADDR_CMP_B_LO))
         compare_value_b_r <= {high_latch_r, i_writedata[7:0]};
   end

   // control and enable registers; force bits are strobes and never stored
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         irq_enable_r <= RESET_BYTE;
         waveform_mode_select_r <= 4'h0;
         capture_edge_select_r <= 1'b0;
         capture_noise_filter_enable_r <= 1'b0;
         capture_source_comparator_r <= 1'b0;
      end
      else if (wr_go && (i_address == ADDR_IRQ_ENABLE))
         irq_enable_r <= i_writedata[7:0] & EVENT_MASK;
      else if (wr_go && (i_address == ADDR_CONTROL))
      begin
         waveform_mode_select_r <= i_writedata[CTL_MODE_MSB:CTL_MODE_LSB];
         capture_edge_select_r <= i_writedata[CTL_EDGE];
         capture_noise_filter_enable_r <= i_writedata[CTL_FILTER];
         capture_source_comparator_r <= i_writedata[CTL_SRC_CMP];
      end
   end

   // capture input: pin or comparator, then optional four-sample filter
   assign capture_raw = capture_source_comparator_r ? i_comparator_out : i_capture_pin;
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         sample_r <= '0;
         filtered_r <= 1'b0;
      end
      else
      begin
         sample_r <= {sample_r[FILTER_DEPTH-2:0], capture_raw};
         if (&sample_r)
            filtered_r <= 1'b1;
         else if (~|sample_r)
            filtered_r <= 1'b0;
      end
   end
   assign capture_in = capture_noise_filter_enable_r ? filtered_r : sample_r[0];

   // edge detect; the input is ignored while capture value is TOP
   assign capture_edge = (capture_in != capture_level_r) &&
                         (capture_in == capture_edge_select_r);
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         capture_level_r <= 1'b0;
         capture_event_r <= 1'b0;
      end
      else
      begin
         capture_level_r <= capture_in;
         capture_event_r <= capture_edge && !mode_cap_top;
      end
   end

   // capture value: hardware capture wins over a software low-byte write
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         capture_value_r <= RESET_WORD;
      else if (capture_event_r)
         capture_value_r <= i_count_value;
      else if (wr_go && (i_address == ADDR_CAP_LO))
         capture_value_r <= {high_latch_r, i_writedata[7:0]};
   end

   // a counter write blocks matches until the next timer tick has passed
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         match_block_r <= 1'b0;
      else if (i_count_written)
         match_block_r <= 1'b1;
      else if (i_count_tick)
         match_block_r <= 1'b0;
   end

   // match detection on each tick; flags follow one cycle later
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         match_a_r <= 1'b0;
         match_b_r <= 1'b0;
         top_reach_r <= 1'b0;
      end
      else
      begin
         match_a_r <= i_count_tick && !match_block_r && !i_count_written &&
                      (i_count_value == compare_value_a_r);
         match_b_r <= i_count_tick && !match_block_r && !i_count_written &&
                      (i_count_value == compare_value_b_r);
         top_reach_r <= i_count_tick && mode_cap_top &&
                        (i_count_value == capture_value_r);
      end
   end

   // strobes to the waveform unit include forced compares
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         o_compare_a_match <= 1'b0;
         o_compare_b_match <= 1'b0;
         o_capture_is_top <= 1'b0;
      end
      else
      begin
         o_compare_a_match <= match_a_r || force_a;
         o_compare_b_match <= match_b_r || force_b;
         o_capture_is_top <= mode_cap_top;
      end
   end

   // flag sets and clears; force strobes take no part in setting
   always_comb
   begin
      flag_set = 8'h00;
      flag_set[BIT_CAP] = capture_event_r || top_reach_r;
      flag_set[BIT_CMP_A] = match_a_r;
      flag_set[BIT_CMP_B] = match_b_r;
      flag_set[BIT_OVF] = i_count_overflow;
      flag_clr = 8'h00;
      if (wr_go && (i_address == ADDR_EVENT_FLAGS))
         flag_clr = i_writedata[7:0] & EVENT_MASK;
      flag_clr[BIT_CAP] = flag_clr[BIT_CAP] || i_capture_vector_taken;
      flag_clr[BIT_CMP_A] = flag_clr[BIT_CMP_A] || i_compare_a_vector_taken;
      flag_clr[BIT_CMP_B] = flag_clr[BIT_CMP_B] || i_compare_b_vector_taken;
      flag_clr[BIT_OVF] = flag_clr[BIT_OVF] || i_overflow_vector_taken;
      flag_nxt = ((event_flags_r & ~flag_clr) | flag_set) & EVENT_MASK;
   end

   // event flag register
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         event_flags_r <= RESET_BYTE;
      else
         event_flags_r <= flag_nxt;
   end

   // requests and mirrored values; global enable gating sits in the controller
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         o_capture_irq <= 1'b0;
         o_compare_a_irq <= 1'b0;
         o_compare_b_irq <= 1'b0;
         o_overflow_irq <= 1'b0;
         o_capture_value <= RESET_WORD;
         o_compare_value_a <= RESET_WORD;
         o_compare_value_b <= RESET_WORD;
      end
      else
      begin
         o_capture_irq <= flag_nxt[BIT_CAP] && irq_enable_r[BIT_CAP];
         o_compare_b_irq <= flag_nxt[BIT_CMP_B] && irq_enable_r[BIT_CMP_B];
         o_compare_a_irq <= flag_nxt[BIT_CMP_A] && irq_enable_r[BIT_CMP_A];
         o_overflow_irq <= flag_nxt[BIT_OVF] && irq_enable_r[BIT_OVF];
         o_capture_value <= capture_value_r;
         o_compare_value_a <= compare_value_a_r;
         o_compare_value_b <= compare_value_b_r;
      end
   end

   // checks
   AST_CMP_A_FLAG: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_count_tick && !match_block_r && !i_count_written &&
       i_count_value == compare_value_a_r) |-> ##2 event_flags_r[BIT_CMP_A])
      else $error("compare A flag not set two cycles after match");
   AST_CMP_B_FLAG: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_count_tick && !match_block_r && !i_count_written &&
       i_count_value == compare_value_b_r) |-> ##2 event_flags_r[BIT_CMP_B])
      else $error("compare B flag not set two cycles after match");
   AST_BLOCK: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_count_written ##1 i_count_tick && !i_count_written) |=> !match_a_r && !match_b_r)
      else $error("match seen on tick after counter write");
   AST_FORCE_NO_FLAG: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (force_a && !match_a_r && !event_flags_r[BIT_CMP_A]) |=> !event_flags_r[BIT_CMP_A])
      else $error("forced compare set the flag");
   AST_RESERVED_ZERO: assert property (@(posedge i_core_clk) disable iff (i_reset)
      ((event_flags_r | irq_enable_r) & ~EVENT_MASK) == 8'h00)
      else $error("reserved bit set");
   AST_SET_WINS: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_count_overflow && flag_clr[BIT_OVF]) |=> event_flags_r[BIT_OVF])
      else $error("clear beat overflow set");
   AST_W1C: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (wr_go && i_address == ADDR_EVENT_FLAGS && i_writedata[BIT_CMP_A] && !match_a_r)
      |=> !event_flags_r[BIT_CMP_A])
      else $error("write one did not clear compare A flag");
   AST_IRQ_CAP: assert property (@(posedge i_core_clk) disable iff (i_reset)
      !$past(i_reset) |->
      o_capture_irq == ($past(flag_nxt[BIT_CAP]) && $past(irq_enable_r[BIT_CAP])))
      else $error("capture request mismatch");
   AST_IRQ_OVF: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (event_flags_r[BIT_OVF] && irq_enable_r[BIT_OVF]) |-> ##[0:1] o_overflow_irq)
      else $error("overflow request missing");
   AST_CAPTURE_LOAD: assert property (@(posedge i_core_clk) disable iff (i_reset)
      capture_event_r |=> capture_value_r == $past(i_count_value) && event_flags_r[BIT_CAP])
      else $error("capture did not load count");
   AST_TOP_DISCONNECT: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (mode_cap_top && $past(mode_cap_top)) |-> !capture_event_r)
      else $error("capture while capture value is TOP");
   AST_LATCH_HIGH: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (rd_go && i_address == ADDR_CAP_LO) |=> high_latch_r == $past(capture_value_r[15:8]))
      else $error("high byte not latched on low read");
   AST_COMMIT: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (wr_go && i_address == ADDR_CMP_A_LO)
      |=> compare_value_a_r == {$past(high_latch_r), $past(i_writedata[7:0])})
      else $error("compare A commit wrong");
   AST_FILTER: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (!$past(i_reset) && $changed(filtered_r)) |->
      $past(sample_r) == {FILTER_DEPTH{filtered_r}})
      else $error("filter changed without four equal samples");
   AST_CAP_VECTOR: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_capture_vector_taken && !capture_event_r && !top_reach_r) |=> !event_flags_r[BIT_CAP])
      else $error("capture vector did not clear capture flag");
   AST_OVF_VECTOR: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_overflow_vector_taken && !i_count_overflow) |=> !event_flags_r[BIT_OVF])
      else $error("overflow vector did not clear overflow flag");

   COV_CAPTURE: cover property (@(posedge i_core_clk) capture_event_r);
   COV_CMP_A_IRQ: cover property (@(posedge i_core_clk) o_compare_a_irq);
   COV_TOP_CAP: cover property (@(posedge i_core_clk) top_reach_r);
   COV_SET_CLR: cover property (@(posedge i_core_clk) i_count_overflow && flag_clr[BIT_OVF]);

endmodule

// ==== hw/timer16_cc_pkg.sv ====
// constants for the 16-bit timer compare, capture and flag block
package timer16_cc_pkg;
   // byte addresses, one 32-bit word per register
   localparam logic [5:0] ADDR_IRQ_ENABLE = 6'h00;
   localparam logic [5:0] ADDR_EVENT_FLAGS = 6'h04;
   localparam logic [5:0] ADDR_CMP_A_LO = 6'h08;
   localparam logic [5:0] ADDR_CMP_A_HI = 6'h0C;
   localparam logic [5:0] ADDR_CMP_B_LO = 6'h10;
   localparam logic [5:0] ADDR_CMP_B_HI = 6'h14;
   localparam logic [5:0] ADDR_CAP_LO = 6'h18;
   localparam logic [5:0] ADDR_CAP_HI = 6'h1C;
   localparam logic [5:0] ADDR_CONTROL = 6'h20;
   // bit positions shared by enable and flag registers
   localparam int BIT_OVF = 0;
   localparam int BIT_CMP_A = 1;
   localparam int BIT_CMP_B = 2;
   localparam int BIT_CAP = 5;
   localparam logic [7:0] EVENT_MASK = 8'h27;
   // control register fields
   localparam int CTL_MODE_LSB = 0;
   localparam int CTL_MODE_MSB = 3;
   localparam int CTL_EDGE = 4;
   localparam int CTL_FILTER = 5;
   localparam int CTL_SRC_CMP = 6;
   localparam int CTL_FORCE_B = 8;
   localparam int CTL_FORCE_A = 9;
   // waveform modes whose TOP is the capture value
   localparam logic [3:0] MODE_PFC_CAP = 4'h8;
   localparam logic [3:0] MODE_PC_CAP = 4'hA;
   localparam logic [3:0] MODE_CTC_CAP = 4'hC;
   localparam logic [3:0] MODE_FAST_CAP = 4'hE;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam int FILTER_DEPTH = 4;
endpackage

// ==== tb/timer16_cc_tb.sv ====
// self-checking bench for the timer compare, capture and flag block
`timescale 1ns/1ps
module timer16_cc_tb
   import timer16_cc_pkg::*;
;
   // one row: optional write, then a read with its expected byte
   typedef struct packed {
      logic wen;
      logic [5:0] wa;
      logic [7:0] wd;
      logic [5:0] ra;
      logic [7:0] re;
   } row_t;
   localparam row_t ROWS [8] = '{
      '{1'b0, 6'h00, 8'h00, ADDR_IRQ_ENABLE, 8'h00},
      '{1'b0, 6'h00, 8'h00, ADDR_EVENT_FLAGS, 8'h00},
      '{1'b1, ADDR_IRQ_ENABLE, 8'hFF, ADDR_IRQ_ENABLE, 8'h27},
      '{1'b1, ADDR_CMP_A_HI, 8'hAB, ADDR_CMP_A_LO, 8'h00},
      '{1'b1, ADDR_CMP_A_LO, 8'hCD, ADDR_CMP_A_HI, 8'hAB},
      '{1'b1, ADDR_CMP_B_HI, 8'h01, ADDR_CMP_B_HI, 8'h00},
      '{1'b1, ADDR_CMP_B_LO, 8'h80, ADDR_CMP_B_LO, 8'h80},
      '{1'b1, 6'h24, 8'h55, 6'h24, 8'h00}};
   logic i_core_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_read = 1'b0;
   logic i_write = 1'b0;
   logic [5:0] i_address = 6'h00;
   logic [31:0] i_writedata = 32'h0;
   logic [3:0] i_byteenable = 4'hF;
   logic [15:0] i_count_value = 16'h0000;
   logic i_count_tick = 1'b0;
   logic i_count_written = 1'b0;
   logic i_count_overflow = 1'b0;
   logic i_capture_pin = 1'b0;
   logic i_comparator_out = 1'b0;
   logic [3:0] vec = 4'h0;
   logic [31:0] o_readdata;
   logic o_waitrequest, o_compare_a_match, o_compare_b_match, o_capture_is_top;
   logic [15:0] o_capture_value, o_compare_value_a, o_compare_value_b;
   logic o_capture_irq, o_compare_a_irq, o_compare_b_irq, o_overflow_irq;
   int n_mismatch = 0;
   int compares = 0;
   int n_force = 0;

   timer16_cc uut (
      .i_core_clk, .i_reset, .i_address, .i_read, .i_write, .i_writedata,
      .i_byteenable, .o_readdata, .o_waitrequest, .i_count_value, .i_count_tick,
      .i_count_written, .i_count_overflow, .i_capture_pin, .i_comparator_out,
      .i_capture_vector_taken(vec[3]), .i_compare_a_vector_taken(vec[2]),
      .i_compare_b_vector_taken(vec[1]), .i_overflow_vector_taken(vec[0]),
      .o_compare_a_match, .o_compare_b_match, .o_capture_is_top, .o_capture_value,
      .o_compare_value_a, .o_compare_value_b, .o_capture_irq, .o_compare_a_irq,
      .o_compare_b_irq, .o_overflow_irq);

   always #5 i_core_clk = ~i_core_clk;

   // strobe counter, so a pulse inside a bus wait is not missed
   always @(posedge i_core_clk)
      if (o_compare_a_match === 1'b1)
         n_force++;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // bus cycles hold until waitrequest is sampled low, then release
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_address <= a;
      i_writedata <= d;
      i_write <= 1'b1;
      do @(posedge i_core_clk); while (o_waitrequest !== 1'b0);
      i_write <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      @(posedge i_core_clk);
      i_address <= a;
      i_read <= 1'b1;
      do @(posedge i_core_clk); while (o_waitrequest !== 1'b0);
      chk(o_readdata, e);
      i_read <= 1'b0;
   endtask

   // settle a little after the edge so registered outputs have landed
   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask

   // one-cycle count step, or a counter write without a step
   task automatic tick(input logic [15:0] c, input logic w);
      @(posedge i_core_clk);
      i_count_value <= c;
      i_count_written <= w;
      i_count_tick <= ~w;
      @(posedge i_core_clk);
      i_count_written <= 1'b0;
      i_count_tick <= 1'b0;
   endtask

   // overflow pulse in bit 4, vector pulses below it
   task automatic ev(input logic [4:0] v);
      @(posedge i_core_clk);
      {i_count_overflow, vec} <= v;
      @(posedge i_core_clk);
      {i_count_overflow, vec} <= 5'h00;
   endtask

   task automatic pin(input logic [15:0] c, input logic p);
      @(posedge i_core_clk);
      i_count_value <= c;
      i_capture_pin <= p;
   endtask

   task automatic stop_test;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // all tests should finish in a few hundred cycles
   initial
   begin
      repeat (20000) @(posedge i_core_clk);
      n_mismatch++;
      stop_test();
   end

   initial
   begin
      repeat (10) @(posedge i_core_clk);
      i_reset <= 1'b0;
      foreach (ROWS[i])
      begin
         if (ROWS[i].wen)
            wr(ROWS[i].wa, {24'h0, ROWS[i].wd});
         rd(ROWS[i].ra, {24'h0, ROWS[i].re});
      end
      rd(ADDR_CMP_B_HI, 32'h01);
      chk(o_compare_value_a, 16'hABCD);
      chk(o_compare_value_b, 16'h0180);
      $display("test registers done");
      tick(16'hABCD, 1'b0);
      cyc(1);
      chk(o_compare_a_match, 1'b1);
      chk(o_compare_a_irq, 1'b1);
      cyc(1);
      chk(o_compare_a_match, 1'b0);
      rd(ADDR_EVENT_FLAGS, 32'h02);
      ev(5'h04);
      cyc(2);
      chk(o_compare_a_irq, 1'b0);
      rd(ADDR_EVENT_FLAGS, 32'h00);
      $display("test compare a done");
      // counter write then the next step: that step must not match
      tick(16'h0180, 1'b1);
      tick(16'h0180, 1'b0);
      cyc(2);
      rd(ADDR_EVENT_FLAGS, 32'h00);
      tick(16'h0180, 1'b0);
      cyc(1);
      chk(o_compare_b_irq, 1'b1);
      chk(o_compare_b_match, 1'b1);
      rd(ADDR_EVENT_FLAGS, 32'h04);
      wr(ADDR_EVENT_FLAGS, 32'h04);
      rd(ADDR_EVENT_FLAGS, 32'h00);
      $display("test compare b done");
      n_force = 0;
      wr(ADDR_CONTROL, 32'h200);
      cyc(4);
      chk(n_force, 1);
      rd(ADDR_EVENT_FLAGS, 32'h00);
      $display("test force done");
      ev(5'h10);
      cyc(2);
      chk(o_overflow_irq, 1'b1);
      rd(ADDR_EVENT_FLAGS, 32'h01);
      ev(5'h01);
      cyc(2);
      rd(ADDR_EVENT_FLAGS, 32'h00);
      ev(5'h10);
      wr(ADDR_EVENT_FLAGS, 32'h01);
      rd(ADDR_EVENT_FLAGS, 32'h00);
      // overflow and its vector in one cycle: the set wins
      ev(5'h11);
      cyc(2);
      rd(ADDR_EVENT_FLAGS, 32'h01);
      wr(ADDR_EVENT_FLAGS, 32'h01);
      $display("test overflow done");
      wr(ADDR_CONTROL, 32'h10);
      pin(16'h1234, 1'b1);
      cyc(3);
      chk(o_capture_irq, 1'b1);
      pin(16'h5555, 1'b1);
      rd(ADDR_CAP_LO, 32'h34);
      rd(ADDR_CAP_HI, 32'h12);
      wr(ADDR_EVENT_FLAGS, 32'h20);
      rd(ADDR_EVENT_FLAGS, 32'h00);
      // falling edge selected: fall captures, rise is ignored
      wr(ADDR_CONTROL, 32'h00);
      pin(16'h4321, 1'b0);
      cyc(2);
      pin(16'h7777, 1'b1);
      cyc(3);
      rd(ADDR_CAP_LO, 32'h21);
      rd(ADDR_CAP_HI, 32'h43);
      ev(5'h08);
      cyc(2);
      rd(ADDR_EVENT_FLAGS, 32'h00);
      $display("test capture done");
      wr(ADDR_CONTROL, {28'h0, MODE_CTC_CAP});
      cyc(2);
      chk(o_capture_is_top, 1'b1);
      pin(16'h1111, 1'b0);
      cyc(3);
      rd(ADDR_EVENT_FLAGS, 32'h00);
      chk(o_capture_value, 16'h4321);
      tick(16'h4321, 1'b0);
      cyc(1);
      rd(ADDR_EVENT_FLAGS, 32'h20);
      $display("test capture top done");
      // comparator source through the filter: a three-sample pulse is dropped
      wr(ADDR_EVENT_FLAGS, 32'h20);
      wr(ADDR_CONTROL, 32'h70);
      rd(ADDR_CONTROL, 32'h70);
      @(posedge i_core_clk);
      i_count_value <= 16'h1357;
      i_comparator_out <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      i_comparator_out <= 1'b0;
      cyc(8);
      rd(ADDR_EVENT_FLAGS, 32'h00);
      @(posedge i_core_clk);
      i_count_value <= 16'h2468;
      i_comparator_out <= 1'b1;
      cyc(10);
      rd(ADDR_CAP_LO, 32'h68);
      rd(ADDR_CAP_HI, 32'h24);
      rd(ADDR_EVENT_FLAGS, 32'h20);
      chk(o_capture_irq, 1'b1);
      $display("test filter done");
      // mid-run reset: requests, flags and enables return to zero
      @(posedge i_core_clk);
      i_reset <= 1'b1;
      cyc(3);
      chk(o_capture_irq, 1'b0);
      chk(o_waitrequest, 1'b1);
      @(posedge i_core_clk);
      i_reset <= 1'b0;
      rd(ADDR_EVENT_FLAGS, 32'h00);
      rd(ADDR_IRQ_ENABLE, 32'h00);
      chk(o_compare_value_a, 16'h0000);
      $display("test reset done");
      stop_test();
   end
endmodule
